// File: mse_encoder.sv
// How it works
// - bpsk points sit at 0 or 180 degrees
// - half rate gives two symbols per bit
// - uncoded skips encoder, one symbol per bit
// - bpsk rate 9.6k to 3.15M only
// - qpsk points at 45/135/225/315 degrees
// - qpsk rate limits per code rate
// - 8-psk trellis: two bits, three symbols
// - 8-psk groups differentially phase encoded
// - 8-psk eight phases 45 degrees apart
// - 8-psk uses self-synchronizing scrambler
// - 8-psk symbol rate is half data rate
// - 8-psk outer code freely selectable
// - k=7 rate 1/2 inner code
// - rate 3/4: four symbols per three bits
// - rate 7/8: eight symbols per seven bits
// - 16-qam maps four symbols to sixteen points
// - 16-qam has no ambiguity encoder
// - 16-qam without outer code: self-sync scrambler
// - 16-qam outer code off only in test
// - 16-qam with outer code: synchronous scrambler
// - 16-qam rate 58k/68k to 9.3M
// - rate 3/4 deletes two of six
`timescale 1ns/1ns
`default_nettype none

module mse_encoder
	import mse_pkg::*;
#(
	parameter int unsigned RATE_W = 24
)
(
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	input  wire logic [1:0]        i_mod,
	input  wire logic [2:0]        i_code_rate,
	input  wire logic              i_outer_code_en,
	input  wire logic              i_test_mode,
	input  wire logic [RATE_W-1:0] i_data_rate_bps,
	output logic                   o_cfg_error,
	output logic                   o_cfg_busy,
	output logic                   o_link_active,
	output logic                   o_outer_code_en,
	input  wire logic              i_transmit_serial_clock,
	input  wire logic              i_tx_valid,
	input  wire logic              i_tx_bit,
	output logic                   o_tx_ready,
	output logic                   o_sym_valid,
	output logic [IQ_W-1:0]        o_sym_i,
	output logic [IQ_W-1:0]        o_sym_q,
	output logic [3:0]             o_sym_code
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic      en;
		mse_mod_e  mod;
		mse_rate_e rate;
		logic      rs;
		logic      req;
		logic      ack_m;
		logic      ack_s;
		logic      act_m;
		logic      act_s;
		logic      err;
	} mse_core_s;

	typedef struct packed {
		logic             rst_m;
		logic             rst_s;
		logic             req_m;
		logic             req_s;
		logic             seen;
		logic             en;
		mse_mod_e         mod;
		mse_rate_e        rate;
		logic             syncscr;
		logic [SCR_W-1:0] scr;
		logic [2:0]       ph;
		logic [1:0]       pend;
		logic [1:0]       pcnt;
		logic [3:0]       grp;
		logic [2:0]       gcnt;
		logic [2:0]       pph;
		logic [IQ_W-1:0]  oi;
		logic [IQ_W-1:0]  oq;
		logic             ovld;
		logic [3:0]       ocode;
	} mse_link_s;

	mse_core_s        cq_q;
	mse_core_s        cq_d;
	mse_link_s        lq_q;
	mse_link_s        lq_d;
	logic             cfg_ok_now;
	logic [6:0]       cfg_new;
	logic             capture;
	logic             accept;
	logic             fb;
	logic             sbit;
	logic             enc_coded;
	logic             enc_x;
	logic             enc_y;
	logic             enc_raw;
	logic             enc_vld;
	logic             raw1;
	logic             ux;
	logic             uy;
	logic [2:0]       last;
	logic [3:0]       g;
	logic [2:0]       gc;
	logic [2:0]       np;
	logic [2*IQ_W-1:0] pt;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [IQ_W-1:0] neg(input logic [IQ_W-1:0] a);
		neg = 8'h00 - a;
	endfunction

	function automatic logic in_range(input logic [RATE_W-1:0] r, input int unsigned lo,
		input int unsigned hi);
		in_range = (32'(r) >= lo) && (32'(r) <= hi);
	endfunction

	function automatic logic cfg_ok(input mse_mod_e m, input mse_rate_e c, input logic rs,
		input logic tst, input logic [RATE_W-1:0] r);
		cfg_ok = 1'b0;
		case (m)
			MSE_BPSK:
				cfg_ok = (c == MSE_R12 || c == MSE_R11) && in_range(r, BPSK_MIN, BPSK_MAX);
			MSE_QPSK:
				case (c)
					MSE_R12: cfg_ok = in_range(r, QPSK12_MIN, QPSK12_MAX);
					MSE_R34: cfg_ok = in_range(r, QPSK34_MIN, HIGH_MAX);
					MSE_R78: cfg_ok = in_range(r, QPSK78_MIN, HIGH_MAX);
					MSE_R11: cfg_ok = in_range(r, QPSK11_MIN, HIGH_MAX);
					default: cfg_ok = 1'b0;
				endcase
			// outer code on or off are both normal here
			MSE_8PSK:
				cfg_ok = (c == MSE_R23) && in_range(r, PSK8_MIN, HIGH_MAX);
			MSE_QAM16:
				case (c)
					MSE_R34: cfg_ok = in_range(r, QAM34_MIN, HIGH_MAX) && (rs || tst);
					MSE_R78: cfg_ok = in_range(r, QAM78_MIN, HIGH_MAX) && (rs || tst);
					default: cfg_ok = 1'b0;
				endcase
			default:
				cfg_ok = 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] group_size(input mse_mod_e m);
		case (m)
			MSE_BPSK:  group_size = GRP_BPSK;
			MSE_QPSK:  group_size = GRP_QPSK;
			MSE_8PSK:  group_size = GRP_8PSK;
			default:   group_size = GRP_QAM;
		endcase
	endfunction

	function automatic logic [IQ_W-1:0] qam_lvl(input logic [1:0] b);
		case (b)
			2'h0:    qam_lvl = neg(QAM_OUT);
			2'h1:    qam_lvl = neg(QAM_IN);
			2'h3:    qam_lvl = QAM_IN;
			default: qam_lvl = QAM_OUT;
		endcase
	endfunction

	function automatic logic [2*IQ_W-1:0] map_point(input mse_mod_e m, input logic [3:0] s,
		input logic [2:0] p);
		map_point = '0;
		case (m)
			MSE_BPSK:
				map_point = {s[0] ? neg(AMP_FULL) : AMP_FULL, 8'h00};
			MSE_QPSK:
				map_point = {s[1] ? neg(AMP_DIAG) : AMP_DIAG,
					s[0] ? neg(AMP_DIAG) : AMP_DIAG};
			MSE_8PSK:
				case (p)
					3'h0:    map_point = {AMP_FULL, 8'h00};
					3'h1:    map_point = {AMP_DIAG, AMP_DIAG};
					3'h2:    map_point = {8'h00, AMP_FULL};
					3'h3:    map_point = {neg(AMP_DIAG), AMP_DIAG};
					3'h4:    map_point = {neg(AMP_FULL), 8'h00};
					3'h5:    map_point = {neg(AMP_DIAG), neg(AMP_DIAG)};
					3'h6:    map_point = {8'h00, neg(AMP_FULL)};
					default: map_point = {AMP_DIAG, neg(AMP_DIAG)};
				endcase
			default:
				map_point = {qam_lvl(s[3:2]), qam_lvl(s[1:0])};
		endcase
	endfunction

	// ****************************************
	// core domain: configuration check and hand-off
	// ****************************************
	assign cfg_ok_now = cfg_ok(mse_mod_e'(i_mod), mse_rate_e'(i_code_rate), i_outer_code_en,
		i_test_mode, i_data_rate_bps);
	assign cfg_new = {cfg_ok_now, i_mod, i_code_rate, i_outer_code_en};

	always_comb
	begin
		cq_d = cq_q;
		cq_d.ack_m = lq_q.seen;
		cq_d.ack_s = cq_q.ack_m;
		cq_d.act_m = lq_q.en;
		cq_d.act_s = cq_q.act_m;
		cq_d.err = !cfg_ok_now;
		// hold words stay frozen until the link domain has taken the last set
		if (cq_q.req == cq_q.ack_s && cfg_new != {cq_q.en, cq_q.mod, cq_q.rate, cq_q.rs})
		begin
			cq_d.en = cfg_ok_now;
			cq_d.mod = mse_mod_e'(i_mod);
			cq_d.rate = mse_rate_e'(i_code_rate);
			cq_d.rs = i_outer_code_en;
			cq_d.req = ~cq_q.req;
		end
		if (!i_rst_n)
			cq_d = '0;
	end

	always_ff @(posedge i_core_clk)
		cq_q <= cq_d;

	assign o_cfg_error     = cq_q.err;
	assign o_cfg_busy      = cq_q.req != cq_q.ack_s;
	assign o_link_active   = cq_q.act_s;
	assign o_outer_code_en = cq_q.rs & cq_q.en;

	AST_REJECT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(!cfg_ok_now && cq_q.req == cq_q.ack_s) |=> (cq_q.err && !cq_q.en))
		else $error("illegal configuration was enabled");

	// ****************************************
	// link domain: scrambler, inner code, mapper
	// ****************************************
	assign capture = lq_q.req_s != lq_q.seen;
	// bits are taken on the source's own clock, one per handshake
	assign o_tx_ready = lq_q.rst_s && lq_q.en && !capture && lq_q.pcnt == 2'h0
		&& !enc_vld;
	assign accept = o_tx_ready && i_tx_valid;
	assign fb = lq_q.scr[SCR_TAP_A] ^ lq_q.scr[SCR_TAP_B];
	assign sbit = i_tx_bit ^ fb;
	// first bit of an 8-psk pair stays uncoded, the second feeds the trellis
	assign enc_coded = lq_q.rate != MSE_R11 && !(lq_q.rate == MSE_R23 && lq_q.ph == 3'h0);

	mse_conv_enc u_conv (
		.i_clk   (i_transmit_serial_clock),
		.i_rst_n (lq_q.rst_s),
		.i_clear (capture),
		.i_go    (accept),
		.i_coded (enc_coded),
		.i_bit   (sbit),
		.o_x     (enc_x),
		.o_y     (enc_y),
		.o_raw   (enc_raw),
		.o_vld   (enc_vld)
	);

	always_comb
	begin
		lq_d = lq_q;
		lq_d.rst_m = i_rst_n;
		lq_d.rst_s = lq_q.rst_m;
		lq_d.req_m = cq_q.req;
		lq_d.req_s = lq_q.req_m;
		lq_d.ovld = 1'b0;
		raw1 = lq_q.rate == MSE_R11 || (lq_q.rate == MSE_R23 && lq_q.ph == 3'h0);
		ux = 1'b1;
		uy = 1'b1;
		last = 3'h0;
		case (lq_q.rate)
			MSE_R34:
			begin
				ux = P34_X[lq_q.ph];
				uy = P34_Y[lq_q.ph];
				last = LAST_R34;
			end
			MSE_R78:
			begin
				ux = P78_X[lq_q.ph];
				uy = P78_Y[lq_q.ph];
				last = LAST_R78;
			end
			MSE_R23:
				last = LAST_R23;
			default:
				last = 3'h0;
		endcase
		g = {lq_q.grp[2:0], lq_q.pend[0]};
		gc = lq_q.gcnt + 3'h1;
		np = lq_q.pph + g[2:0];
		pt = map_point(lq_q.mod, g, np);

		if (accept)
			// the synchronous variant runs free of the data, the other feeds back its output
			lq_d.scr = lq_q.syncscr ? {lq_q.scr[SCR_W-2:0], fb}
				: {lq_q.scr[SCR_W-2:0], sbit};

		if (enc_vld)
		begin
			if (raw1)
			begin
				lq_d.pend = {1'b0, enc_raw};
				lq_d.pcnt = 2'h1;
			end
			else if (ux && uy)
			begin
				lq_d.pend = {enc_y, enc_x};
				lq_d.pcnt = 2'h2;
			end
			else
			begin
				lq_d.pend = {1'b0, ux ? enc_x : enc_y};
				lq_d.pcnt = 2'h1;
			end
			lq_d.ph = (lq_q.ph == last) ? 3'h0 : lq_q.ph + 3'h1;
		end
		else if (lq_q.pcnt != 2'h0)
		begin
			lq_d.pend = {1'b0, lq_q.pend[1]};
			lq_d.pcnt = lq_q.pcnt - 2'h1;
			if (gc == group_size(lq_q.mod))
			begin
				// only 8-psk accumulates phase; 16-qam is mapped straight
				if (lq_q.mod == MSE_8PSK)
					lq_d.pph = np;
				lq_d.oi = pt[2*IQ_W-1:IQ_W];
				lq_d.oq = pt[IQ_W-1:0];
				lq_d.ovld = 1'b1;
				lq_d.ocode = g;
				lq_d.grp = 4'h0;
				lq_d.gcnt = 3'h0;
			end
			else
			begin
				lq_d.grp = g;
				lq_d.gcnt = gc;
			end
		end

		if (capture)
		begin
			lq_d.seen = lq_q.req_s;
			lq_d.en = cq_q.en;
			lq_d.mod = cq_q.mod;
			lq_d.rate = cq_q.rate;
			lq_d.syncscr = cq_q.rs && cq_q.mod == MSE_QAM16;
			lq_d.scr = SCR_SEED;
			lq_d.ph = 3'h0;
			lq_d.pend = 2'h0;
			lq_d.pcnt = 2'h0;
			lq_d.grp = 4'h0;
			lq_d.gcnt = 3'h0;
			lq_d.pph = 3'h0;
		end

		// the link clock must run while reset is low for this to take effect
		if (!lq_q.rst_s)
		begin
			lq_d = '0;
			lq_d.rst_m = i_rst_n;
			lq_d.rst_s = lq_q.rst_m;
			lq_d.req_m = cq_q.req;
			lq_d.req_s = lq_q.req_m;
			lq_d.seen = lq_q.req_s;
		end
	end

	always_ff @(posedge i_transmit_serial_clock)
		lq_q <= lq_d;

	assign o_sym_valid = lq_q.ovld;
	assign o_sym_i     = lq_q.oi;
	assign o_sym_q     = lq_q.oq;
	assign o_sym_code  = lq_q.ocode;

	// ****************************************
	// checks
	// ****************************************
	AST_BPSK_POINT: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(o_sym_valid && lq_q.mod == MSE_BPSK) |->
		(o_sym_q == 8'h00 && (o_sym_i == AMP_FULL || o_sym_i == neg(AMP_FULL))))
		else $error("bpsk point off axis");

	AST_QPSK_POINT: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(o_sym_valid && lq_q.mod == MSE_QPSK) |->
		((o_sym_i == AMP_DIAG || o_sym_i == neg(AMP_DIAG))
		&& (o_sym_q == AMP_DIAG || o_sym_q == neg(AMP_DIAG))))
		else $error("qpsk point not on a diagonal");

	AST_8PSK_PHASE: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(o_sym_valid && lq_q.mod == MSE_8PSK && !$past(capture)) |->
		(lq_q.pph == 3'($past(lq_q.pph) + lq_q.ocode[2:0])))
		else $error("8-psk phase not accumulated");

	AST_QAM_POINT: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(o_sym_valid && lq_q.mod == MSE_QAM16) |->
		(o_sym_i == qam_lvl(o_sym_code[3:2]) && o_sym_q == qam_lvl(o_sym_code[1:0])))
		else $error("16-qam point wrong");

	AST_HALF_TWO: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(enc_vld && !capture && lq_q.rate == MSE_R12) |=> (lq_q.pcnt == 2'h2))
		else $error("half rate did not give two symbols");

	AST_UNCODED_ONE: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(enc_vld && !capture && lq_q.rate == MSE_R11) |=> (lq_q.pcnt == 2'h1 ##1 lq_q.pcnt == 2'h0))
		else $error("uncoded bit did not give one symbol");

	AST_P34: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(enc_vld && !capture && lq_q.rate == MSE_R34 && lq_q.ph != 3'h0) |=> (lq_q.pcnt == 2'h1))
		else $error("rate 3/4 puncture wrong");

	AST_P78: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		(enc_vld && !capture && lq_q.rate == MSE_R78 && lq_q.ph == 3'h4) |=> (lq_q.pcnt == 2'h1))
		else $error("rate 7/8 puncture wrong");

	AST_RESTART: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		capture |=> (lq_q.ph == 3'h0 && lq_q.pcnt == 2'h0 && lq_q.gcnt == 3'h0
		&& !enc_vld && lq_q.grp == 4'h0))
		else $error("reconfiguration did not restart");

	AST_SYNC_SCR: assert property (@(posedge i_transmit_serial_clock)
		disable iff (!lq_q.rst_s)
		capture |=> (lq_q.syncscr == ($past(cq_q.rs) && lq_q.mod == MSE_QAM16)))
		else $error("scrambler choice wrong");

endmodule // mse_encoder

`default_nettype wire

// File: mse_pkg.sv
package mse_pkg;

	// ****************************************
	// modes
	// ****************************************
	typedef enum logic [1:0] {MSE_BPSK, MSE_QPSK, MSE_8PSK, MSE_QAM16} mse_mod_e;
	typedef enum logic [2:0] {MSE_R11, MSE_R12, MSE_R34, MSE_R78, MSE_R23} mse_rate_e;

	// ****************************************
	// inner code, k=7 rate 1/2 (171/133 octal)
	// ****************************************
	localparam int unsigned CONV_MEM = 6;
	localparam logic [6:0]  CONV_G1  = 7'h79;
	localparam logic [6:0]  CONV_G2  = 7'h5b;

	// puncture masks, bit n = phase n keeps that symbol
	localparam logic [6:0] P34_X    = 7'h05;
	localparam logic [6:0] P34_Y    = 7'h03;
	localparam logic [6:0] P78_X    = 7'h51;
	localparam logic [6:0] P78_Y    = 7'h2f;
	localparam logic [2:0] LAST_R34 = 3'h2;
	localparam logic [2:0] LAST_R78 = 3'h6;
	localparam logic [2:0] LAST_R23 = 3'h1;

	// symbols per constellation point
	localparam logic [2:0] GRP_BPSK = 3'h1;
	localparam logic [2:0] GRP_QPSK = 3'h2;
	localparam logic [2:0] GRP_8PSK = 3'h3;
	localparam logic [2:0] GRP_QAM  = 3'h4;

	// ****************************************
	// scramblers, 1 + x^-14 + x^-15
	// ****************************************
	localparam int unsigned SCR_W     = 15;
	localparam int unsigned SCR_TAP_A = 13;
	localparam int unsigned SCR_TAP_B = 14;
	localparam logic [14:0] SCR_SEED  = 15'h4a80;

	// ****************************************
	// constellation amplitudes, two's complement
	// ****************************************
	localparam int unsigned IQ_W     = 8;
	localparam logic [7:0]  AMP_FULL = 8'h60;
	localparam logic [7:0]  AMP_DIAG = 8'h44;
	localparam logic [7:0]  QAM_IN   = 8'h20;
	localparam logic [7:0]  QAM_OUT  = 8'h60;

	// ****************************************
	// data rate limits in bit/s
	// ****************************************
	localparam int unsigned BPSK_MIN   = 9600;
	localparam int unsigned BPSK_MAX   = 3150000;
	localparam int unsigned QPSK12_MIN = 19000;
	localparam int unsigned QPSK12_MAX = 6300000;
	localparam int unsigned QPSK34_MIN = 28500;
	localparam int unsigned QPSK78_MIN = 33250;
	localparam int unsigned QPSK11_MIN = 38400;
	localparam int unsigned PSK8_MIN   = 38400;
	localparam int unsigned QAM34_MIN  = 58000;
	localparam int unsigned QAM78_MIN  = 68000;
	localparam int unsigned HIGH_MAX   = 9300000;

endpackage

// File: mse_conv_enc.sv
`timescale 1ns/1ns
`default_nettype none

module mse_conv_enc
	import mse_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_clear,
	input  wire logic i_go,
	input  wire logic i_coded,
	input  wire logic i_bit,
	output logic      o_x,
	output logic      o_y,
	output logic      o_raw,
	output logic      o_vld
);

	typedef struct packed {
		logic [CONV_MEM-1:0] sr;
		logic                x;
		logic                y;
		logic                raw;
		logic                vld;
	} mse_enc_s;

	mse_enc_s q_q;
	mse_enc_s q_d;
	logic [CONV_MEM:0] word;

	function automatic logic parity(input logic [CONV_MEM:0] w, input logic [CONV_MEM:0] g);
		parity = ^(w & g);
	endfunction

	always_comb
	begin
		q_d = q_q;
		q_d.vld = 1'b0;
		word = {i_bit, q_q.sr};
		if (i_go)
		begin
			q_d.x = parity(word, CONV_G1);
			q_d.y = parity(word, CONV_G2);
			q_d.raw = i_bit;
			q_d.vld = 1'b1;
			// uncoded bits leave the trellis untouched
			if (i_coded)
				q_d.sr = word[CONV_MEM:1];
		end
		if (i_clear || !i_rst_n)
			q_d = '0;
	end

	always_ff @(posedge i_clk)
		q_q <= q_d;

	assign o_x   = q_q.x;
	assign o_y   = q_q.y;
	assign o_raw = q_q.raw;
	assign o_vld = q_q.vld;

endmodule // mse_conv_enc

`default_nettype wire

// File: mse_src_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// interface card: serial bits on the link clock
// ****************************************
module mse_src_model
	import mse_pkg::*;
(
	input  wire logic i_transmit_serial_clock,
	input  wire logic i_rst_n,
	input  wire logic i_slow,
	input  wire logic i_tx_ready,
	output var logic  o_tx_valid = 1'b0,
	output var logic  o_tx_bit = 1'b0
);
	logic bits_q[$];
	logic idle_q = 1'b0;

	task automatic push(input logic b);
		bits_q.push_back(b);
	endtask

	// data and its qualifier change only after a link edge and stay until taken
	always @(posedge i_transmit_serial_clock)
	begin
		if (!i_rst_n)
		begin
			o_tx_valid <= 1'b0;
			idle_q     <= 1'b0;
		end
		else if (idle_q)
		begin
			idle_q     <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_bit   <= ~o_tx_bit;
		end
		else if (!o_tx_valid || i_tx_ready)
		begin
			idle_q <= o_tx_valid & i_slow;
			if (bits_q.size() > 0 && !(o_tx_valid & i_slow))
			begin
				o_tx_valid <= 1'b1;
				o_tx_bit   <= bits_q.pop_front();
			end
			else
			begin
				// released line shows no stale bit
				o_tx_valid <= 1'b0;
				o_tx_bit   <= ~o_tx_bit;
			end
		end
	end
endmodule // mse_src_model

`default_nettype wire

// File: mse_encoder_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`define MSE_CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
	$display("BAD %s exp %0h got %0h", nm, exp, got); end end

module mse_encoder_tb_top
	import mse_pkg::*;
;
	logic        clk = 1'b0;
	logic        lclk;
	logic        rst_n = 1'b0;
	logic        slow = 1'b0;
	logic [1:0]  mod_r = 2'h1;
	logic [2:0]  rate_r = 3'h1;
	logic        outer_r = 1'b0;
	logic        test_r = 1'b0;
	logic [23:0] bps_r = 24'h00fa00;
	logic        tx_valid;
	logic        tx_bit;
	logic        cfg_error, cfg_busy, link_active, outer_en, tx_ready, sym_valid;
	logic [7:0]  sym_i, sym_q;
	logic [3:0]  sym_code;
	int          fails = 0;
	int          n_tests = 0;
	int          pts = 0;
	logic [2:0]  acc8 = 3'h0;

	always #4 clk = ~clk;
	initial
	begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end

	mse_encoder i_mse_encoder (.i_core_clk(clk), .i_rst_n(rst_n), .i_mod(mod_r),
		.i_code_rate(rate_r), .i_outer_code_en(outer_r), .i_test_mode(test_r),
		.i_data_rate_bps(bps_r), .o_cfg_error(cfg_error), .o_cfg_busy(cfg_busy),
		.o_link_active(link_active), .o_outer_code_en(outer_en),
		.i_transmit_serial_clock(lclk), .i_tx_valid(tx_valid), .i_tx_bit(tx_bit),
		.o_tx_ready(tx_ready), .o_sym_valid(sym_valid), .o_sym_i(sym_i),
		.o_sym_q(sym_q), .o_sym_code(sym_code));

	mse_src_model i_mse_src_model (.i_transmit_serial_clock(lclk), .i_rst_n(rst_n),
		.i_slow(slow), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid), .o_tx_bit(tx_bit));

	// ****************************************
	// point shape monitor
	// ****************************************
	function automatic logic pm(input logic [7:0] x, input logic [7:0] a);
		return (x === a) || (x === 8'h00 - a);
	endfunction

	function automatic logic ok_pt(input logic [1:0] m, input logic [7:0] i, input logic [7:0] q);
		case (m)
			2'h0: return (q === 8'h00) && pm(i, AMP_FULL);
			2'h1: return pm(i, AMP_DIAG) && pm(q, AMP_DIAG);
			2'h2: return (i === 8'h00 && pm(q, AMP_FULL)) || (q === 8'h00 && pm(i, AMP_FULL))
				|| (pm(i, AMP_DIAG) && pm(q, AMP_DIAG));
			default: return (pm(i, QAM_IN) || pm(i, QAM_OUT)) && (pm(q, QAM_IN) || pm(q, QAM_OUT));
		endcase
	endfunction

	function automatic logic [7:0] sgn(input logic b, input logic [7:0] a);
		return b ? 8'h00 - a : a;
	endfunction

	// gray per axis: the second symbol picks the inner ring, the first the sign
	function automatic logic [7:0] lvl(input logic [1:0] b);
		return sgn(!b[1], b[0] ? QAM_IN : QAM_OUT);
	endfunction

	function automatic logic [15:0] exp_pt(input logic [1:0] m, input logic [3:0] c);
		case (m)
			2'h0: return {sgn(c[0], AMP_FULL), 8'h00};
			2'h1: return {sgn(c[1], AMP_DIAG), sgn(c[0], AMP_DIAG)};
			default: return {lvl(c[3:2]), lvl(c[1:0])};
		endcase
	endfunction

	// phases counterclockwise from the positive i axis, 45 degrees apart
	function automatic logic [15:0] psk8(input logic [2:0] p);
		case (p)
			3'h0: return {AMP_FULL, 8'h00};
			3'h1: return {AMP_DIAG, AMP_DIAG};
			3'h2: return {8'h00, AMP_FULL};
			3'h3: return {sgn(1'b1, AMP_DIAG), AMP_DIAG};
			3'h4: return {sgn(1'b1, AMP_FULL), 8'h00};
			3'h5: return {sgn(1'b1, AMP_DIAG), sgn(1'b1, AMP_DIAG)};
			3'h6: return {8'h00, sgn(1'b1, AMP_FULL)};
			default: return {AMP_DIAG, sgn(1'b1, AMP_DIAG)};
		endcase
	endfunction

	// sampled mid-cycle so the pulse launched at the rising edge has settled
	always @(negedge lclk)
		if (sym_valid === 1'b1)
		begin
			pts++;
			// differential phase: each 8-psk group advances the phase by its own value
			acc8 = acc8 + sym_code[2:0];
			`MSE_CHK("point", 1'b1, ok_pt(mod_r, sym_i, sym_q))
			if (mod_r == 2'h2)
				`MSE_CHK("psk8_point", psk8(acc8), {sym_i, sym_q})
			else
				`MSE_CHK("code_map", exp_pt(mod_r, sym_code), {sym_i, sym_q})
		end

	// ****************************************
	// tasks
	// ****************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cfg(input mse_mod_e m, input mse_rate_e r, input logic oc, input logic tm,
		input logic [23:0] bps);
		int k;
		@(posedge clk);
		mod_r   <= m;
		rate_r  <= r;
		outer_r <= oc;
		test_r  <= tm;
		bps_r   <= bps;
		repeat (3) @(posedge clk);
		k = 0;
		while (cfg_busy !== 1'b0 && k < 500)
		begin
			@(posedge clk);
			k++;
		end
		repeat (40) @(posedge clk);
		`MSE_CHK("cfg_busy", 1'b0, cfg_busy)
	endtask

	task automatic chk_cfg(input mse_mod_e m, input mse_rate_e r, input logic oc, input logic tm,
		input logic [23:0] bps, input logic e);
		cfg(m, r, oc, tm, bps);
		`MSE_CHK("cfg_error", e, cfg_error)
		if (e)
		begin
			`MSE_CHK("tx_ready", 1'b0, tx_ready)
			`MSE_CHK("link_active", 1'b0, link_active)
		end
	endtask

	task automatic run(input mse_mod_e m, input mse_rate_e r, input logic oc, input logic tm,
		input int nb, input int ep);
		int base;
		int k;
		cfg(m, r, oc, tm, 24'h0f4240);
		`MSE_CHK("link_active", 1'b1, link_active)
		`MSE_CHK("outer_en", oc, outer_en)
		base = pts;
		acc8 = 3'h0;
		for (k = 0; k < nb; k++)
			i_mse_src_model.push(k[0] ^ k[2]);
		k = 0;
		while (pts - base < ep && k < 2000)
		begin
			@(posedge lclk);
			k++;
		end
		// extra points after the expected ones would show a wrong ratio
		repeat (40) @(posedge lclk);
		`MSE_CHK("points", ep, pts - base)
		$display("test done mod %0d rate %0d bits %0d", m, r, nb);
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk_cfg(MSE_BPSK, MSE_R12, 1'b0, 1'b0, 24'h002580, 1'b0);
		chk_cfg(MSE_BPSK, MSE_R12, 1'b0, 1'b0, 24'h00257f, 1'b1);
		chk_cfg(MSE_BPSK, MSE_R12, 1'b0, 1'b0, 24'h3010b0, 1'b0);
		chk_cfg(MSE_BPSK, MSE_R12, 1'b0, 1'b0, 24'h3010b1, 1'b1);
		chk_cfg(MSE_QPSK, MSE_R12, 1'b0, 1'b0, 24'h602161, 1'b1);
		chk_cfg(MSE_QPSK, MSE_R34, 1'b0, 1'b0, 24'h8de820, 1'b0);
		chk_cfg(MSE_QPSK, MSE_R78, 1'b0, 1'b0, 24'h8de821, 1'b1);
		chk_cfg(MSE_QPSK, MSE_R11, 1'b0, 1'b0, 24'h0095ff, 1'b1);
		chk_cfg(MSE_QAM16, MSE_R34, 1'b1, 1'b0, 24'h00e28f, 1'b1);
		chk_cfg(MSE_QAM16, MSE_R78, 1'b1, 1'b0, 24'h0109a0, 1'b0);
		chk_cfg(MSE_QAM16, MSE_R34, 1'b0, 1'b0, 24'h0f4240, 1'b1);
		chk_cfg(MSE_QAM16, MSE_R34, 1'b0, 1'b1, 24'h0f4240, 1'b0);
		chk_cfg(MSE_QAM16, MSE_R12, 1'b1, 1'b0, 24'h0f4240, 1'b1);
		chk_cfg(MSE_8PSK, MSE_R23, 1'b0, 1'b0, 24'h0f4240, 1'b0);
		chk_cfg(MSE_8PSK, MSE_R23, 1'b1, 1'b0, 24'h0f4240, 1'b0);
		chk_cfg(MSE_BPSK, mse_rate_e'(3'h5), 1'b0, 1'b0, 24'h0f4240, 1'b1);
		$display("test done configuration table");
		run(MSE_BPSK, MSE_R11, 1'b0, 1'b0, 5, 5);
		run(MSE_BPSK, MSE_R12, 1'b0, 1'b0, 4, 8);
		run(MSE_QPSK, MSE_R11, 1'b0, 1'b0, 4, 2);
		slow <= 1'b1;
		run(MSE_QPSK, MSE_R12, 1'b0, 1'b0, 4, 4);
		slow <= 1'b0;
		run(MSE_QPSK, MSE_R34, 1'b0, 1'b0, 6, 4);
		run(MSE_QPSK, MSE_R78, 1'b0, 1'b0, 7, 4);
		run(MSE_8PSK, MSE_R23, 1'b0, 1'b0, 4, 2);
		run(MSE_QAM16, MSE_R34, 1'b1, 1'b0, 6, 2);
		run(MSE_QAM16, MSE_R78, 1'b1, 1'b0, 7, 2);
		run(MSE_QAM16, MSE_R34, 1'b0, 1'b1, 3, 1);
		run(MSE_QAM16, MSE_R34, 1'b1, 1'b0, 1, 0);
		run(MSE_BPSK, MSE_R11, 1'b0, 1'b0, 3, 3);
		finish_test();
	end

	initial
	begin
		#600000;
		fails++;
		finish_test();
	end
endmodule // mse_encoder_tb_top

`default_nettype wire
